// ===== ftf_buffer_model.sv
// Track buffer memory model with prompt or slow answer
`timescale 1ns/10ps
`default_nettype none
module ftf_buffer_model (
   // Control
   input wire logic        mclk,
   input wire logic        slow,
   // Memory port
   input wire logic [13:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [7:0]  mem_wdata,
   output logic            mem_ack,
   output logic [7:0]      mem_rdata
);
   // ====================
   // Storage holds its low address byte at start
   logic [7:0] m [0:16383];
   logic [1:0] wt;
   initial begin
      for (int i = 0; i < 16384; i++) m[i] = i[7:0];
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      wt = 2'h0;
   end
   always @(posedge mclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if ((mem_rd || mem_wr) && !mem_ack) begin
         if (slow && wt != 2'h3) wt <= wt + 2'h1;
         else begin
            wt <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_wr) m[mem_addr] <= mem_wdata;
            else mem_rdata <= m[mem_addr];
         end
      end
   end
endmodule // ftf_buffer_model
`default_nettype wire

// ===== ftf_consts.vh
// Constants for the floppy track flow-control block
`ifndef FTF_CONSTS_VH
`define FTF_CONSTS_VH
// Register addresses
`define FTF_ADDR_CTRL1      3'h0
`define FTF_ADDR_CTRL2      3'h3
`define FTF_ADDR_CLR_EDGES  3'h4
`define FTF_ADDR_CLR_DIRTY  3'h5
`define FTF_ADDR_BASE_LO    3'h6
`define FTF_ADDR_BASE_HI    3'h7
// Field positions
`define FTF_BIT_EN_DMA      5
`define FTF_BIT_DIRTY       2
`define FTF_BIT_EDGE_LO     4
// Reset values
`define FTF_RST_CTRL1       8'h00
`define FTF_RST_BASE        14'h0000
// Track geometry in bytes
`define FTF_TRACK_STORED    6656
`define FTF_TRACK_PLAYED    6392
// Timing: one byte every 768 clocks at 25 MHz
`define FTF_CLK_MHZ         25
`define FTF_BYTE_CYCLES     768
`endif

// ===== ftf_skid_buffer.v
// Two-entry valid/ready buffer
`timescale 1ns/10ps
`default_nettype none
module ftf_skid_buffer #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             mclk,
   input  wire             resetn,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   // Flush
   input  wire             flush
);
   reg  [WIDTH-1:0] entry [0:1];
   reg              rd_ptr;
   reg              wr_ptr;
   reg  [1:0]       count;
   wire             push;
   wire             pop;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = entry[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else if (flush) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            count <= count + 2'h1;
         end else if (pop && !push) begin
            count <= count - 2'h1;
         end
      end
   end

   always @(posedge mclk) begin
      if (push) begin
         entry[wr_ptr] <= in_data;
      end
   end
endmodule // ftf_skid_buffer
`default_nettype wire

// ===== ftf_track_flow.v
// Track playback DMA and flow control of the emulated floppy drive
//
// Summary of operation
// (R1) Rising edge on phase zero or phase two marks a track change.
// (R2) DMA stays disabled during track refresh; nothing played or captured.
// (R3) Wait-for-write is high exactly while DMA is off and write requested; the code registers it, so it follows one cycle late.
// (R4) Host halts CPU and 2MHz disk clocks while wait-for-write is high.
// (R5) Tracks store 6656 bytes; only the first 6392 bytes are ever played.
// (R6) Host write data arriving while DMA is disabled is discarded.
// (R7) Host waits for the phase pulse falling edge before disk access.
// (R8) Host reads sector address field before writing, so it waits.
// (R9) Address counter increments continually, reloading base at track end.
// (R10) Dirty flag set on each DMA write, cleared by its strobe.
// (R11) Per-phase edge flags set on rising edges; any set requests interrupt.
// (R12) Enable bit five of control register one gates all disk DMA.
// (R13) Wait-for-write held low during reset.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ftf_consts.vh"
module ftf_track_flow #(
   parameter ADDR_W      = 14,
   parameter TRACK_BYTES = `FTF_TRACK_PLAYED,
   parameter BYTE_CYCLES = `FTF_BYTE_CYCLES
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              resetn,
   // Register port
   input  wire [2:0]        reg_addr,
   input  wire [7:0]        reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [7:0]        reg_rdata,
   // Stepper phases from host
   input  wire [3:0]        stepper_phase,
   // Host bitstream side
   input  wire              host_write_req,
   input  wire              host_wr_valid,
   input  wire [7:0]        host_wr_data,
   output reg               host_rd_valid,
   output reg  [7:0]        host_rd_data,
   input  wire              host_rd_ready,
   output reg               wait_for_write,
   // Track buffer memory port
   output reg  [ADDR_W-1:0] mem_addr,
   output reg               mem_rd,
   output reg               mem_wr,
   output reg  [7:0]        mem_wdata,
   input  wire              mem_ack,
   input  wire [7:0]        mem_rdata,
   // Firmware signals
   output reg               irq_req,
   output reg               track_change
);
   // =================================================================
   // Registers
   reg  [7:0]        ctrl1;
   reg  [3:0]        phase_edge_flags;
   reg  [3:0]        phase_prev;
   reg               dirty;
   reg  [ADDR_W-1:0] base_addr;
   reg  [ADDR_W-1:0] offset;
   reg  [15:0]       byte_tick_cnt;
   reg  [1:0]        state;
   reg  [7:0]        wr_hold;
   reg               wr_hold_valid;
   wire              dma_en;
   wire [3:0]        rise;
   wire              byte_tick;
   wire              buf_in_ready;
   wire              buf_out_valid;
   wire [7:0]        buf_out_data;
   reg               buf_in_valid;

   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WRIT = 2'h2;

   assign dma_en    = ctrl1[`FTF_BIT_EN_DMA];                   // [R12]
   assign rise      = stepper_phase & ~phase_prev;
   assign byte_tick = (byte_tick_cnt == BYTE_CYCLES - 1);

   function [ADDR_W-1:0] wrap_next;
      input [ADDR_W-1:0] cur;
      begin
         if (cur == TRACK_BYTES - 1) begin
            wrap_next = {ADDR_W{1'b0}};                          // [R5] [R9]
         end else begin
            wrap_next = cur + 1'b1;
         end
      end
   endfunction

   // =================================================================
   // Register access and flags
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl1            <= `FTF_RST_CTRL1;
         base_addr        <= `FTF_RST_BASE;
         phase_prev       <= 4'h0;
         phase_edge_flags <= 4'h0;
         dirty            <= 1'b0;
         reg_rdata        <= 8'h00;
         irq_req          <= 1'b0;
         track_change     <= 1'b0;
         wait_for_write   <= 1'b0;                               // [R13]
      end else begin
         phase_prev   <= stepper_phase;
         track_change <= rise[0] | rise[2];                      // [R1]
         if (reg_wr && reg_addr == `FTF_ADDR_CTRL1) begin
            ctrl1 <= reg_wdata;
         end
         if (reg_wr && reg_addr == `FTF_ADDR_BASE_LO) begin
            base_addr[7:0] <= reg_wdata;
         end
         if (reg_wr && reg_addr == `FTF_ADDR_BASE_HI) begin
            base_addr[ADDR_W-1:8] <= reg_wdata[ADDR_W-9:0];
         end
         // Set wins over clear
         if (reg_wr && reg_addr == `FTF_ADDR_CLR_EDGES) begin
            phase_edge_flags <= rise;                            // [R11]
         end else begin
            phase_edge_flags <= phase_edge_flags | rise;         // [R11]
         end
         if (mem_wr && mem_ack) begin
            dirty <= 1'b1;                                       // [R10]
         end else if (reg_wr && reg_addr == `FTF_ADDR_CLR_DIRTY) begin
            dirty <= 1'b0;                                       // [R10]
         end
         irq_req        <= (|phase_edge_flags) | (|rise);        // [R11]
         wait_for_write <= !dma_en && host_write_req;            // [R3]
         reg_rdata      <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `FTF_ADDR_CTRL1:   reg_rdata <= ctrl1;
               `FTF_ADDR_CTRL2:   reg_rdata <= {phase_edge_flags, 1'b0, dirty, 2'b00};
               `FTF_ADDR_BASE_LO: reg_rdata <= base_addr[7:0];
               `FTF_ADDR_BASE_HI: reg_rdata <= {{(16-ADDR_W){1'b0}}, base_addr[ADDR_W-1:8]};
               default:           reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // =================================================================
   // Byte-rate divider and DMA sequencer
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         byte_tick_cnt <= 16'h0000;
         offset        <= {ADDR_W{1'b0}};
         state         <= ST_IDLE;
         mem_addr      <= {ADDR_W{1'b0}};
         mem_rd        <= 1'b0;
         mem_wr        <= 1'b0;
         mem_wdata     <= 8'h00;
         wr_hold       <= 8'h00;
         wr_hold_valid <= 1'b0;
         buf_in_valid  <= 1'b0;
      end else begin
         if (!dma_en || byte_tick) begin
            byte_tick_cnt <= 16'h0000;
         end else begin
            byte_tick_cnt <= byte_tick_cnt + 16'h0001;
         end
         if (buf_in_valid && buf_in_ready) begin
            buf_in_valid <= 1'b0;
         end
         if (!dma_en) begin
            wr_hold_valid <= 1'b0;                               // [R6]
         end else if (host_wr_valid) begin
            wr_hold       <= host_wr_data;
            wr_hold_valid <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (dma_en && byte_tick) begin                    // [R2]
                  mem_addr <= base_addr + offset;
                  offset   <= wrap_next(offset);                 // [R9]
                  if (host_write_req && wr_hold_valid) begin
                     mem_wr        <= 1'b1;
                     mem_wdata     <= wr_hold;
                     wr_hold_valid <= 1'b0;
                     state         <= ST_WRIT;
                  end else if (!buf_in_valid) begin
                     mem_rd <= 1'b1;
                     state  <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (mem_ack) begin
                  mem_rd       <= 1'b0;
                  buf_in_valid <= dma_en;                        // [R2]
                  state        <= ST_IDLE;
               end
            end
            ST_WRIT: begin
               if (mem_ack) begin
                  mem_wr <= 1'b0;
                  state  <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   reg [7:0] rd_latch;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_latch <= 8'h00;
      end else if (state == ST_READ && mem_ack) begin
         rd_latch <= mem_rdata;
      end
   end

   // =================================================================
   // Playback buffer toward host
   ftf_skid_buffer #(
      .WIDTH (8)
   ) u_buf (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (rd_latch),
      .out_valid (buf_out_valid),
      .out_ready (host_rd_ready || !host_rd_valid),
      .out_data  (buf_out_data),
      .flush     (!dma_en)                                       // [R2]
   );

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         host_rd_valid <= 1'b0;
         host_rd_data  <= 8'h00;
      end else if (!dma_en) begin
         host_rd_valid <= 1'b0;                                  // [R2]
      end else if (host_rd_ready || !host_rd_valid) begin
         host_rd_valid <= buf_out_valid;
         host_rd_data  <= buf_out_data;
      end
   end
endmodule // ftf_track_flow
`default_nettype wire

// ===== ftf_track_flow_properties.sv
// Checker of the track flow-control block ports
`timescale 1ns/10ps
`default_nettype none
module ftf_track_flow_properties #(
   parameter TRACK_BYTES = 6392
) (
   // Clock, reset and register port
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic [2:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Host, memory and firmware sides
   input wire logic [3:0]  stepper_phase,
   input wire logic        host_write_req,
   input wire logic        host_rd_valid,
   input wire logic        wait_for_write,
   input wire logic [13:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        mem_ack,
   input wire logic        irq_req,
   input wire logic        track_change
);
   // ====================
   // Mirror of enable, base, dirty flag and time spent disabled
   logic        en;
   logic [13:0] base;
   logic [3:0]  off;
   logic        dm;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         en   <= 1'b0;
         base <= 14'h0000;
         off  <= 4'h0;
         dm   <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 3'h0) en <= reg_wdata[5];
         if (reg_wr && reg_addr == 3'h6) base[7:0] <= reg_wdata;
         if (reg_wr && reg_addr == 3'h7) base[13:8] <= reg_wdata[5:0];
         off <= en ? 4'h0 : (off == 4'hf ? off : off + 4'h1);
         if (mem_wr && mem_ack) dm <= 1'b1;
         else if (reg_wr && reg_addr == 3'h5) dm <= 1'b0;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   AST_WFW: assert property (wait_for_write == (!$past(en) && $past(host_write_req) && $past(resetn)))
      else $error("wait_for_write wrong");
   AST_WFW_RST: assert property (disable iff (1'b0) !resetn |-> !wait_for_write)
      else $error("wait_for_write high in reset");
   AST_DMA_OFF: assert property (off > 4'h7 |-> !mem_rd && !mem_wr)
      else $error("memory cycle while disabled");
   AST_PLAY_OFF: assert property (off > 4'h7 |-> !host_rd_valid)
      else $error("byte played while disabled");
   AST_RANGE: assert property (mem_rd || mem_wr |-> 14'(mem_addr - base) < TRACK_BYTES)
      else $error("address beyond track");
   AST_HOLD: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("read cycle dropped");
   AST_DIRTY: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[2] == $past(dm))
      else $error("dirty flag wrong");
   AST_EDGE: assert property (|(stepper_phase & ~$past(stepper_phase)) |-> ##[1:2] irq_req)
      else $error("edge gave no request");
   AST_TRACK: assert property ($rose(stepper_phase[0]) || $rose(stepper_phase[2])
      |-> ##[1:2] track_change)
      else $error("track change missed");
   AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read");
endmodule // ftf_track_flow_properties
bind ftf_track_flow ftf_track_flow_properties #(.TRACK_BYTES(TRACK_BYTES)) chk (
   .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stepper_phase,
   .host_write_req, .host_rd_valid, .wait_for_write, .mem_addr, .mem_rd, .mem_wr,
   .mem_ack, .irq_req, .track_change);
`default_nettype wire

// ===== tb_floppy_track_flow_control.sv
// Testbench of the track flow-control block
`timescale 1ns/10ps
`default_nettype none
module tb_floppy_track_flow_control;
   localparam TB = 20;
   logic        mclk, resetn, reg_wr, reg_rd, wreq, wr_valid, rd_ready, slow;
   logic        rd_valid, wfw, mem_rd, mem_wr, mem_ack, irq, tchg;
   logic [2:0]  reg_addr;
   logic [3:0]  phase;
   logic [7:0]  reg_wdata, reg_rdata, wr_data, rd_data, mem_wdata, mem_rdata;
   logic [13:0] mem_addr;
   int          n_errors = 0, comparisons = 0, cyc = 0;
   ftf_track_flow #(.BYTE_CYCLES(8), .TRACK_BYTES(TB)) uut (
      .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stepper_phase(phase),
      .host_write_req(wreq), .host_wr_valid(wr_valid), .host_wr_data(wr_data),
      .host_rd_valid(rd_valid), .host_rd_data(rd_data), .host_rd_ready(rd_ready),
      .wait_for_write(wfw), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_req(irq),
      .track_change(tchg));
   ftf_buffer_model mem (.mclk(mclk), .slow(slow), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ====================
   // Access and compare tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      check(reg_rdata, exp);
   endtask
   task automatic send(input logic [7:0] d);
      @(posedge mclk);
      wr_data <= d;
      wr_valid <= 1'b1;
      @(posedge mclk);
      wr_valid <= 1'b0;
   endtask
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         test_done;
      end
   end
   // Only the byte sent with the DMA on may reach the buffer
   always @(posedge mclk) begin
      if (mem_wr && mem_ack) check(mem_wdata, 8'hc3);
   end
   // ====================
   // Test sequence
   initial begin
      resetn = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, phase} = '0;
      {wr_valid, wr_data, slow} = '0;
      wreq = 1'b1;
      rd_ready = 1'b1;
      repeat (8) @(posedge mclk);
      check({7'h0, wfw}, 8'h00);
      resetn <= 1'b1;
      wreq <= 1'b0;
      rd(3'h0, 8'h00);
      rd(3'h3, 8'h00);
      wr(3'h1, 8'hff);
      rd(3'h1, 8'h00);
      wr(3'h6, 8'h10);
      wr(3'h7, 8'h01);
      rd(3'h6, 8'h10);
      rd(3'h7, 8'h01);
      wr(3'h0, 8'h20);
      rd(3'h0, 8'h20);
      $display("test registers done");
      for (int j = 0; j < 2 * TB + 4; ) begin
         @(posedge mclk);
         if (rd_valid && rd_ready) begin
            check(rd_data, 8'h10 + 8'(j % TB));
            j++;
         end
         rd_ready <= (cyc % 5) != 0;
         slow <= cyc[5];
      end
      rd_ready <= 1'b1;
      $display("test playback done");
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         phase <= 4'(1 << i);
         repeat (2) @(posedge mclk);
         check({7'h0, tchg}, (i == 0 || i == 2) ? 8'h01 : 8'h00);
         @(posedge mclk);
         check({7'h0, irq}, 8'h01);
         phase <= 4'h0;
         rd(3'h3, 8'(8'h10 << i));
         wr(3'h4, 8'h00);
         repeat (2) @(posedge mclk);
         check({7'h0, irq}, 8'h00);
      end
      $display("test phases done");
      wr(3'h0, 8'h00);
      send(8'ha5);
      wreq <= 1'b1;
      repeat (3) @(posedge mclk);
      check({7'h0, wfw}, 8'h01);
      wr(3'h0, 8'h20);
      repeat (3) @(posedge mclk);
      check({7'h0, wfw}, 8'h00);
      repeat (40) @(posedge mclk);
      rd(3'h3, 8'h00);
      while (!rd_valid) @(posedge mclk);
      while (wfw) @(posedge mclk);
      send(8'hc3);
      repeat (40) @(posedge mclk);
      rd(3'h3, 8'h04);
      wreq <= 1'b0;
      wr(3'h5, 8'h00);
      rd(3'h3, 8'h00);
      $display("test write flow done");
      test_done;
   end
endmodule // tb_floppy_track_flow_control
`default_nettype wire
